// ==== usb_frame_number_tracker.sv ====
// Frame number tracker with APB register access
//
// ------------------------------------------------------------
// Overview of operation
// - Create-SOF enable runs frame timer, flags SOF when host token missed.
// - Enabled and no SOF for one frame time: status becomes before.
// - In before status the frame field keeps the last received number.
// - Every SOF token received outside suspend sets status to valid.
// - System reset or suspend puts status into lost.
// - Enabled and no SOF for two frame times: status becomes lost.
// - With enable off, only reset or suspend leads to lost.
// - Each SOF frame number received outside suspend is captured into read-only bits 10:0.
// ------------------------------------------------------------
`timescale 1ns/1ps
module usb_frame_number_tracker
    import usb_frame_pkg::*;
#(
    parameter logic [TIMER_W-1:0] FRAME_CYCLES = FRAME_CYCLES_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sof_token_s sof_token,
    input wire logic suspend,
    output logic sof_flag,
    output logic [1:0] frame_status,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic create_sof;
    logic [FRAME_NUM_W-1:0] frame_number;
    logic [1:0] missed;
    logic tick;
    logic sof_rx;
    logic silent_tick;
    logic wr_en;
    logic setup;
    logic mapped;
    logic [NUM_EVENTS-1:0] irq_enable;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_set;
    logic [NUM_EVENTS-1:0] irq_clear;
    logic [DATA_W-1:0] next_prdata;
    logic [TIMER_W-1:0] before_age;

    // ------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------
    // Suspend overrides a token seen in the same cycle
    assign sof_rx = sof_token.valid && !suspend;
    // A frame boundary passed with no host token
    assign silent_tick = tick && create_sof && !sof_token.valid && !suspend;

    // ------------------------------------------------------------
    // Frame time counter
    // ------------------------------------------------------------
    // Timer stops while disabled so no timeout can ever fire
    frame_timer #(
        .LIMIT(FRAME_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(create_sof && !suspend),
        .restart(sof_rx),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Missed frame count
    // ------------------------------------------------------------
    // Saturates at two; further silent frames keep the lost state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            missed <= 2'h0;
        end else if (sof_rx || suspend || !create_sof) begin
            missed <= 2'h0;
        end else if (silent_tick && missed != LOST_FRAMES) begin
            missed <= missed + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Frame status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_status <= STATUS_RESET;
        end else if (suspend) begin
            frame_status <= FS_LOST;
        end else if (sof_rx) begin
            frame_status <= FS_VALID;
        end else if (silent_tick && missed == BEFORE_FRAMES - 2'h1) begin
            frame_status <= FS_BEFORE;
        end else if (silent_tick && missed == LOST_FRAMES - 2'h1) begin
            frame_status <= FS_LOST;
        end
    end

    // ------------------------------------------------------------
    // Frame number capture
    // ------------------------------------------------------------
    // Held through before and lost so software sees the last token
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_number <= FRAME_RESET;
        end else if (sof_rx) begin
            frame_number <= sof_token.number;
        end
    end

    // ------------------------------------------------------------
    // Start-of-frame flag
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_flag <= 1'b0;
        end else begin
            sof_flag <= sof_rx || silent_tick;
        end
    end

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    always_comb begin
        irq_set = '0;
        irq_set[EV_SOF_RX] = sof_rx;
        irq_set[EV_SOF_SYNTH] = silent_tick;
        irq_set[EV_BEFORE] = silent_tick && missed == 2'h0;
        irq_set[EV_LOST] = (suspend && frame_status != FS_LOST)
            || (silent_tick && missed == BEFORE_FRAMES);
    end

    assign irq_clear = (wr_en && paddr == IRQ_CLEAR_OFFSET) ?
        pwdata[NUM_EVENTS-1:0] : '0;

    event_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .event_set(irq_set),
        .event_clear(irq_clear),
        .event_enable(irq_enable),
        .event_status(irq_status),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One fixed wait-free access: pready rises in the first access cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_comb begin
        next_prdata = '0;
        mapped = 1'b1;
        if (paddr == FRAME_REG_OFFSET) begin
            next_prdata[CREATE_SOF_BIT] = create_sof;
            next_prdata[STATUS_MSB:STATUS_LSB] = frame_status;
            next_prdata[FRAME_MSB:0] = frame_number;
        end else if (paddr == IRQ_STATUS_OFFSET) begin
            next_prdata[NUM_EVENTS-1:0] = irq_status;
        end else if (paddr == IRQ_ENABLE_OFFSET) begin
            next_prdata[NUM_EVENTS-1:0] = irq_enable;
        end else if (paddr == IRQ_CLEAR_OFFSET) begin
            next_prdata = '0;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? next_prdata : '0;
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            create_sof <= CREATE_SOF_RESET;
        end else if (wr_en && paddr == FRAME_REG_OFFSET) begin
            create_sof <= pwdata[CREATE_SOF_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= IRQ_ENABLE_RESET;
        end else if (wr_en && paddr == IRQ_ENABLE_OFFSET) begin
            irq_enable <= pwdata[NUM_EVENTS-1:0];
        end
    end

    // ------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------
    // A delay range cannot span a frame, so the wait is counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            before_age <= '0;
        end else if (missed == 2'h1 && !silent_tick) begin
            before_age <= before_age + 16'h0001;
        end else begin
            before_age <= '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence token_seen;
        sof_token.valid && !suspend;
    endsequence

    sequence first_silent_frame;
        silent_tick && missed == 2'h0;
    endsequence

    sequence second_silent_frame;
        silent_tick && missed == 2'h1;
    endsequence

    chk_synth_flag_on: assert property (
        @(posedge pclk) disable iff (!presetn)
        silent_tick |=> sof_flag
    ) else $error("missed token did not raise the sof flag");

    chk_synth_flag_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !create_sof && !sof_token.valid ##1 !sof_token.valid
            |=> !sof_flag
    ) else $error("sof flag raised with synthesis disabled");

    chk_before_timeout: assert property (
        @(posedge pclk) disable iff (!presetn)
        first_silent_frame |=> frame_status == FS_BEFORE
    ) else $error("one silent frame did not give before status");

    chk_before_frame_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        frame_status == FS_BEFORE && !sof_token.valid
            |=> $stable(frame_number)
    ) else $error("frame number changed while status is before");

    chk_valid_on_token: assert property (
        @(posedge pclk) disable iff (!presetn)
        token_seen |=> frame_status == FS_VALID
    ) else $error("token did not set valid status");

    chk_lost_on_suspend: assert property (
        @(posedge pclk) disable iff (!presetn)
        suspend |=> frame_status == FS_LOST
    ) else $error("suspend did not give lost status");

    chk_lost_timeout: assert property (
        @(posedge pclk) disable iff (!presetn)
        before_age < FRAME_CYCLES
    ) else $error("second silent frame never reached");

    chk_lost_two_frames: assert property (
        @(posedge pclk) disable iff (!presetn)
        second_silent_frame |=> frame_status == FS_LOST
    ) else $error("two silent frames did not give lost status");

    chk_no_timeout_lost: assert property (
        @(posedge pclk) disable iff (!presetn)
        !create_sof && !suspend && frame_status != FS_LOST
            |=> frame_status != FS_LOST
    ) else $error("lost entered without reset or suspend");

    chk_frame_capture: assert property (
        @(posedge pclk) disable iff (!presetn)
        token_seen |=> frame_number == $past(sof_token.number)
    ) else $error("frame number not captured from token");

    chk_status_code: assert property (
        @(posedge pclk) disable iff (!presetn)
        frame_status != FS_RESERVED
    ) else $error("reserved status code produced");

    chk_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        |(irq_status & irq_enable) |=> irq
    ) else $error("enabled event did not raise irq");

    chk_apb_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready
    ) else $error("apb answer not a single cycle after setup");

    chk_timer_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        !create_sof |=> !tick
    ) else $error("frame timer ticked while disabled");

    chk_suspend_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        suspend |=> !sof_flag
    ) else $error("sof flag raised during suspend");

    chk_frame_read_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sof_rx |=> $stable(frame_number)
    ) else $error("frame number changed without a token");

    chk_valid_needs_token: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sof_rx && frame_status != FS_VALID |=> frame_status != FS_VALID
    ) else $error("valid status entered without a token");

    chk_before_needs_tick: assert property (
        @(posedge pclk) disable iff (!presetn)
        !silent_tick && frame_status != FS_BEFORE
            |=> frame_status != FS_BEFORE
    ) else $error("before status entered without a silent frame");

    chk_apb_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        !setup |=> !pready && !pslverr && prdata == '0
    ) else $error("apb outputs active without a setup cycle");

    chk_irq_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_clear[EV_BEFORE] && !irq_set[EV_BEFORE]
            |=> !irq_status[EV_BEFORE]
    ) else $error("irq status bit not cleared by write");

endmodule

// ==== usb_frame_pkg.sv ====
// Shared constants and types of the frame number tracker
package usb_frame_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FRAME_NUM_W = 11;
    localparam int TIMER_W = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] FRAME_REG_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 12'h004;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET = 12'h008;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFSET = 12'h00C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CREATE_SOF_BIT = 15;
    localparam int STATUS_MSB = 13;
    localparam int STATUS_LSB = 12;
    localparam int FRAME_MSB = 10;

    // ------------------------------------------------------------
    // Frame status codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] FS_BEFORE = 2'h0;
    localparam logic [1:0] FS_VALID = 2'h1;
    localparam logic [1:0] FS_LOST = 2'h2;
    localparam logic [1:0] FS_RESERVED = 2'h3;
    localparam logic CREATE_SOF_RESET = 1'b0;
    localparam logic [1:0] STATUS_RESET = FS_LOST;
    localparam logic [FRAME_NUM_W-1:0] FRAME_RESET = 11'h000;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    localparam int NUM_EVENTS = 4;
    localparam int EV_SOF_RX = 0;
    localparam int EV_SOF_SYNTH = 1;
    localparam int EV_BEFORE = 2;
    localparam int EV_LOST = 3;
    localparam logic [NUM_EVENTS-1:0] IRQ_ENABLE_RESET = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int FRAME_TIME_NS = 1000000;
    localparam logic [TIMER_W-1:0] FRAME_CYCLES_DEFAULT =
        TIMER_W'(FRAME_TIME_NS / CLK_PERIOD_NS);
    localparam logic [1:0] BEFORE_FRAMES = 2'h1;
    localparam logic [1:0] LOST_FRAMES = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [FRAME_NUM_W-1:0] number;
    } sof_token_s;

endpackage

// ==== frame_timer.sv ====
// Frame-time divider producing a one-cycle tick per frame
`timescale 1ns/1ps
module frame_timer
    import usb_frame_pkg::*;
#(
    parameter logic [TIMER_W-1:0] LIMIT = FRAME_CYCLES_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic restart,
    output logic tick
);

    logic [TIMER_W-1:0] count;

    // Restart aligns the frame grid to the last host token
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            tick <= 1'b0;
        end else if (!run || restart) begin
            count <= '0;
            tick <= 1'b0;
        end else if (count == LIMIT - 16'h0001) begin
            count <= '0;
            tick <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick <= 1'b0;
        end
    end

endmodule

// ==== event_irq.sv ====
// Sticky event status, enable gating and interrupt output
`timescale 1ns/1ps
module event_irq
    import usb_frame_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_EVENTS-1:0] event_set,
    input wire logic [NUM_EVENTS-1:0] event_clear,
    input wire logic [NUM_EVENTS-1:0] event_enable,
    output logic [NUM_EVENTS-1:0] event_status,
    output logic irq
);

    // Set beats clear so a same-cycle event is never lost
    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                event_status[i] <= 1'b0;
            end else if (event_set[i]) begin
                event_status[i] <= 1'b1;
            end else if (event_clear[i]) begin
                event_status[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_status & event_enable);
        end
    end

endmodule

// ==== sof_host_model.sv ====
// Host side model issuing start-of-frame tokens
`timescale 1ns/1ps
module sof_host_model
    import usb_frame_pkg::*;
(
    input wire logic pclk,
    output sof_token_s sof_token
);
    initial begin
        sof_token <= '0;
    end

    // ------------------------------------------------------------
    // Token issue
    // ------------------------------------------------------------
    // Idle number shows the inverse, so a stale value is never trusted
    task automatic send(input logic [FRAME_NUM_W-1:0] n, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        sof_token <= {1'b1, n};
        @(posedge pclk);
        sof_token <= {1'b0, ~n};
    endtask
endmodule

// ==== usb_frame_number_tracker_tb_top.sv ====
// Self-checking bench of the frame number tracker
`timescale 1ns/1ps
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        miscompares++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, a, b); \
    end \
end
module usb_frame_number_tracker_tb_top;
    import usb_frame_pkg::*;
    localparam logic [TIMER_W-1:0] FC = 16'h0014;
    logic pclk, presetn, psel, penable, pwrite, suspend;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic pready, pslverr, sof_flag, irq;
    logic [1:0] frame_status;
    sof_token_s sof_token;
    int miscompares, samples_checked, cyc, t0, t1;

    usb_frame_number_tracker #(.FRAME_CYCLES(FC)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sof_token(sof_token),
        .suspend(suspend), .sof_flag(sof_flag),
        .frame_status(frame_status), .irq(irq));
    sof_host_model i_host (.pclk(pclk), .sof_token(sof_token));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Counted by NBA so a read at the edge never races the increment
    always @(posedge pclk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) miscompares++;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask

    // Returns the cycle count at the next flag pulse
    task automatic wait_flag(output int t);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (sof_flag !== 1'b1 && n < 100);
        t = cyc;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        #1;
        `CHK(frame_status, FS_LOST)
        `CHK({sof_flag, irq}, 2'h0)
        rd(FRAME_REG_OFFSET, 32'h0000_2000, 1'b0);
        rd(IRQ_ENABLE_OFFSET, 32'h0000_0000, 1'b0);
    endtask

    task automatic t_sof_rx();
        i_host.send(11'h7FF, 0);
        i_host.send(11'h000, 0);
        #1;
        `CHK(frame_status, FS_VALID)
        `CHK(sof_flag, 1'b1)
        rd(FRAME_REG_OFFSET, 32'h0000_1000, 1'b0);
        i_host.send(11'h5A5, 2);
        wr(FRAME_REG_OFFSET, 32'h0000_37FF);
        rd(FRAME_REG_OFFSET, 32'h0000_15A5, 1'b0);
    endtask

    task automatic t_no_synth();
        int cnt;
        cnt = 0;
        repeat (3 * FC + 10) begin
            @(posedge pclk);
            #1;
            if (sof_flag === 1'b1) cnt++;
        end
        `CHK(cnt, 0)
        `CHK(frame_status, FS_VALID)
    endtask

    task automatic t_synth();
        wr(FRAME_REG_OFFSET, 32'h0000_8000);
        i_host.send(11'h155, 0);
        t0 = cyc;
        wait_flag(t1);
        `CHK(t1 - t0 >= FC && t1 - t0 <= FC + 3, 1'b1)
        `CHK(frame_status, FS_BEFORE)
        rd(FRAME_REG_OFFSET, 32'h0000_8155, 1'b0);
        wait_flag(t0);
        `CHK(t0 - t1 >= FC && t0 - t1 <= FC + 2, 1'b1)
        `CHK(frame_status, FS_LOST)
        wait_flag(t1);
        `CHK(frame_status, FS_LOST)
        wr(FRAME_REG_OFFSET, 32'h0000_0000);
        rd(FRAME_REG_OFFSET, 32'h0000_2155, 1'b0);
    endtask

    task automatic t_irq();
        rd(IRQ_STATUS_OFFSET, 32'h0000_000F, 1'b0);
        `CHK(irq, 1'b0)
        wr(IRQ_ENABLE_OFFSET, 32'h0000_0004);
        @(posedge pclk);
        #1;
        `CHK(irq, 1'b1)
        wr(IRQ_CLEAR_OFFSET, 32'h0000_0004);
        rd(IRQ_STATUS_OFFSET, 32'h0000_000B, 1'b0);
        `CHK(irq, 1'b0)
        wr(IRQ_CLEAR_OFFSET, 32'h0000_000F);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        rd(IRQ_CLEAR_OFFSET, 32'h0000_0000, 1'b0);
        rd(12'h010, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_suspend();
        i_host.send(11'h3C3, 0);
        suspend <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK(frame_status, FS_LOST)
        i_host.send(11'h001, 0);
        #1;
        `CHK({frame_status, sof_flag}, {FS_LOST, 1'b0})
        rd(FRAME_REG_OFFSET, 32'h0000_23C3, 1'b0);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0009, 1'b0);
        suspend <= 1'b0;
    endtask

    task automatic t_midreset();
        wr(FRAME_REG_OFFSET, 32'h0000_8000);
        i_host.send(11'h0AA, 0);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK({frame_status, irq}, {FS_LOST, 1'b0})
        @(posedge pclk);
        presetn <= 1'b1;
        rd(FRAME_REG_OFFSET, 32'h0000_2000, 1'b0);
        rd(IRQ_ENABLE_OFFSET, 32'h0000_0000, 1'b0);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        {presetn, psel, penable, pwrite, suspend} <= 5'h00;
        paddr <= 12'h000;
        pwdata <= 32'h0000_0000;
        miscompares = 0;
        samples_checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sof_rx();
        t_no_synth();
        t_synth();
        t_irq();
        t_suspend();
        t_midreset();
        report_and_stop();
    end
endmodule
